// [rtl/bad_pkg.sv]
// Purpose: shared constants and carriers for the branch and ALU decode block
// Assumes: 32-bit instructions, combined program counter and status word
// Notes:   APB offsets are byte addresses of 32-bit words
package bad_pkg;

  // condition codes, top four bits of every instruction
  localparam logic [3:0] COND_EQUAL = 4'h0;
  localparam logic [3:0] COND_NE = 4'h1;
  localparam logic [3:0] COND_CS = 4'h2;
  localparam logic [3:0] COND_CC = 4'h3;
  localparam logic [3:0] COND_MI = 4'h4;
  localparam logic [3:0] COND_PL = 4'h5;
  localparam logic [3:0] COND_VS = 4'h6;
  localparam logic [3:0] COND_VC = 4'h7;
  localparam logic [3:0] COND_HI = 4'h8;
  localparam logic [3:0] COND_LS = 4'h9;
  localparam logic [3:0] COND_GE = 4'hA;
  localparam logic [3:0] COND_LT = 4'hB;
  localparam logic [3:0] COND_GT = 4'hC;
  localparam logic [3:0] COND_LE = 4'hD;
  localparam logic [3:0] COND_ALWAYS = 4'hE;
  localparam logic [3:0] COND_NEVER = 4'hF;

  // ALU opcodes
  localparam logic [3:0] OP_AND = 4'h0;
  localparam logic [3:0] OP_EOR = 4'h1;
  localparam logic [3:0] OP_SUB = 4'h2;
  localparam logic [3:0] OP_RSB = 4'h3;
  localparam logic [3:0] OP_ADD = 4'h4;
  localparam logic [3:0] OP_ADC = 4'h5;
  localparam logic [3:0] OP_SBC = 4'h6;
  localparam logic [3:0] OP_RSC = 4'h7;
  localparam logic [3:0] OP_TEST_AND = 4'h8;
  localparam logic [3:0] OP_TEST_XOR = 4'h9;
  localparam logic [3:0] OP_COMPARE_SUB = 4'hA;
  localparam logic [3:0] OP_COMPARE_ADD = 4'hB;
  localparam logic [3:0] OP_ORR = 4'hC;
  localparam logic [3:0] OP_MOV = 4'hD;
  localparam logic [3:0] OP_BIC = 4'hE;
  localparam logic [3:0] OP_MVN = 4'hF;
  localparam logic [1:0] OP_TEST_HI = 2'h2;

  // instruction classes and register indexes
  localparam logic [2:0] CLS_BRANCH     = 3'h5;
  localparam logic [1:0] CLS_ALU        = 2'h0;
  localparam logic [3:0] IDX_LINK       = 4'hE;
  localparam logic [3:0] IDX_PC         = 4'hF;
  localparam logic [23:0] PREFETCH_WORDS = 24'h000002;
  localparam logic [23:0] NEXT_WORD      = 24'h000001;
  localparam int unsigned BRANCH_SHIFT  = 2;

  // APB map
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_STATUS   = 8'h04;
  localparam logic [7:0] OFS_REG_SEL  = 8'h08;
  localparam logic [7:0] OFS_REG_DATA = 8'h0C;
  localparam int unsigned CTRL_RUN_BIT = 0;

  typedef struct packed {
    logic [3:0]  cond;
    logic [1:0]  cls;
    logic        immediate_flag;
    logic [3:0]  opcode;
    logic        set_flags_bit;
    logic [3:0]  operand_first_reg;
    logic [3:0]  dest_reg;
    logic [11:0] operand_two;
  } bad_alu_t;

  typedef struct packed {
    logic [3:0]  cond;
    logic [2:0]  cls;
    logic        link;
    logic [23:0] offset;
  } bad_branch_t;

  typedef struct packed {
    logic        neg_flag;
    logic        zero_flag;
    logic        carry_flag;
    logic        ovf_flag;
    logic        irq_off;
    logic        firq_off;
    logic [23:0] pc_word;
    logic [1:0]  mode;
  } bad_r15_t;

  localparam bad_r15_t R15_RST = 32'h0C000003;

endpackage

// [rtl/bad_core.sv]
// Purpose: decode and execute branch, branch_with_link and ALU-class instructions
// Assumes: fetch path presents words in program order and refetches after a redirect
// Notes:   one instruction per accepted cycle; registers and status_word live here
//
// Implementation choices: register access over APB and the register offsets.

module bad_core
  import bad_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        ce,
  // instruction stream
  input  wire logic        instr_valid,
  input  wire logic [31:0] instr_data,
  output logic             instr_ready,
  // program counter reload from a load_multiple
  input  wire logic        stack_pc_valid,
  input  wire logic [31:0] stack_pc_word,
  input  wire logic        stack_restore,
  // fetch redirect
  output logic             fetch_redirect,
  output logic [25:0]      fetch_target,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr
);

  ////////////////////////////////////////////////////////////////////////////
  // state
  logic [31:0] gpr [0:13];
  logic [31:0] link_bank [0:3];
  bad_r15_t    r15;
  logic        run;
  logic [3:0]  reg_sel;

  function automatic logic cond_pass(input logic [3:0] c, input bad_r15_t s);
    logic p;
    p = 1'b0;
    case (c)
      COND_EQUAL: p = s.zero_flag;
      COND_NE: p = !s.zero_flag;
      COND_CS: p = s.carry_flag;
      COND_CC: p = !s.carry_flag;
      COND_MI: p = s.neg_flag;
      COND_PL: p = !s.neg_flag;
      COND_VS: p = s.ovf_flag;
      COND_VC: p = !s.ovf_flag;
      COND_HI: p = s.carry_flag && !s.zero_flag;
      COND_LS: p = !s.carry_flag || s.zero_flag;
      COND_GE: p = s.neg_flag == s.ovf_flag;
      COND_LT: p = s.neg_flag != s.ovf_flag;
      COND_GT: p = !s.zero_flag && (s.neg_flag == s.ovf_flag);
      COND_LE: p = s.zero_flag || (s.neg_flag != s.ovf_flag);
      COND_ALWAYS: p = 1'b1;
      default: p = 1'b0;
    endcase
    return p;
  endfunction

  // r15 reads as the prefetched value, two words ahead
  function automatic logic [31:0] reg_read(input logic [3:0] idx);
    bad_r15_t v;
    v = r15;
    v.pc_word = r15.pc_word + PREFETCH_WORDS;
    if (idx == IDX_PC) begin
      return v;
    end else if (idx == IDX_LINK) begin
      return link_bank[r15.mode];
    end
    return gpr[idx];
  endfunction

  function automatic logic [31:0] rotr(input logic [31:0] v, input logic [4:0] amt);
    logic [5:0] back;
    back = 6'h20 - {1'b0, amt};
    return (v >> amt) | (v << back);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // decode
  bad_alu_t    ai;
  bad_branch_t bi;
  logic        accept;
  logic        cond_ok;
  logic        exec;
  logic        is_branch;
  logic        is_alu;
  logic [25:0] off_bytes;
  logic [25:0] branch_target;
  logic [23:0] branch_word;
  bad_r15_t    link_value;

  assign ai          = instr_data;
  assign bi          = instr_data;
  // load_multiple reload owns the cycle; a bubble follows every redirect
  assign instr_ready = ce && run && !fetch_redirect && !stack_pc_valid;
  assign accept      = instr_valid && instr_ready;
  assign cond_ok     = cond_pass(ai.cond, r15);
  assign exec        = accept && cond_ok;
  assign is_branch   = bi.cls == CLS_BRANCH;
  assign is_alu      = ai.cls == CLS_ALU;

  assign off_bytes     = {bi.offset, 2'h0};
  assign branch_target = {r15.pc_word + PREFETCH_WORDS, 2'h0} + off_bytes;
  assign branch_word   = branch_target[25:BRANCH_SHIFT];

  always_comb begin
    link_value         = r15;
    link_value.pc_word = r15.pc_word + NEXT_WORD;
  end

  ////////////////////////////////////////////////////////////////////////////
  // operand two and ALU
  logic [31:0] op1;
  logic [31:0] shift_src;
  logic [31:0] op2;
  logic [4:0]  amt;
  logic [31:0] x;
  logic [31:0] y;
  logic        cin;
  logic        arith;
  logic [32:0] sum;
  logic [31:0] res;
  logic        res_c;
  logic        res_v;
  logic        writes_result;

  // register file reads inside a function need a process that tracks them
  always_comb begin
    op1       = reg_read(ai.operand_first_reg);
    shift_src = reg_read(ai.operand_two[3:0]);
  end

  // register counts use the low five bits only; zero leaves shift_src unshifted
  always_comb begin
    amt = ai.operand_two[4] ? 5'(reg_read(ai.operand_two[11:8])) : ai.operand_two[11:7];
    op2 = shift_src;
    if (ai.immediate_flag) begin
      op2 = rotr({24'h000000, ai.operand_two[7:0]}, {ai.operand_two[11:8], 1'b0});
    end else if (!(ai.operand_two[4] && amt == 5'h00)) begin
      case (ai.operand_two[6:5])
        2'h0:    op2 = shift_src << amt;
        2'h1:    op2 = (amt == 5'h00) ? 32'h0 : shift_src >> amt;
        2'h2:    op2 = (amt == 5'h00) ? {32{shift_src[31]}} : 32'($signed(shift_src) >>> amt);
        default: op2 = (amt == 5'h00) ? {r15.carry_flag, shift_src[31:1]} : rotr(shift_src, amt);
      endcase
    end
  end

  always_comb begin
    x     = op1;
    y     = op2;
    cin   = 1'b0;
    arith = 1'b1;
    case (ai.opcode)
      OP_SUB, OP_COMPARE_SUB: begin
        y   = ~op2;
        cin = 1'b1;
      end
      OP_RSB: begin
        x   = op2;
        y   = ~op1;
        cin = 1'b1;
      end
      OP_ADD, OP_COMPARE_ADD: cin = 1'b0;
      OP_ADC: cin = r15.carry_flag;
      OP_SBC: begin
        y   = ~op2;
        cin = r15.carry_flag;
      end
      OP_RSC: begin
        x   = op2;
        y   = ~op1;
        cin = r15.carry_flag;
      end
      default: arith = 1'b0;
    endcase
  end

  assign sum = {1'b0, x} + {1'b0, y} + {32'h0, cin};

  always_comb begin
    res_c = r15.carry_flag;
    res_v = r15.ovf_flag;
    case (ai.opcode)
      OP_AND, OP_TEST_AND: res = op1 & op2;
      OP_EOR, OP_TEST_XOR: res = op1 ^ op2;
      OP_ORR:         res = op1 | op2;
      OP_MOV:         res = op2;
      OP_BIC:         res = op1 & ~op2;
      OP_MVN:         res = ~op2;
      default:        res = sum[31:0];
    endcase
    if (arith) begin
      res_c = sum[32];
      res_v = (x[31] == y[31]) && (sum[31] != x[31]);
    end
  end

  // opcodes 10xx are the test forms
  assign writes_result = ai.opcode[3:2] != OP_TEST_HI;

  logic alu_go;
  logic alu_to_pc;
  logic br_go;
  logic link_go;
  logic apb_wr;
  logic reg_wr;

  assign alu_go    = exec && is_alu;
  assign alu_to_pc = alu_go && writes_result && ai.dest_reg == IDX_PC;
  assign br_go     = exec && is_branch;
  assign link_go   = br_go && bi.link;
  assign apb_wr    = ce && psel && penable && pwrite;
  // register window writes only while halted, so no second writer races the core
  assign reg_wr    = apb_wr && paddr == OFS_REG_DATA && !run;

  ////////////////////////////////////////////////////////////////////////////
  // program counter and status_word
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r15 <= R15_RST;
    end else if (ce) begin
      if (stack_pc_valid) begin
        r15.pc_word <= stack_pc_word[25:2];
        if (stack_restore) begin
          r15 <= stack_pc_word;
        end
      end else if (reg_wr && reg_sel == IDX_PC) begin
        r15 <= pwdata;
      end else if (br_go) begin
        r15.pc_word <= branch_word;
      end else if (alu_to_pc) begin
        r15.pc_word <= res[25:2];
        if (ai.set_flags_bit) begin
          r15 <= res;
        end
      end else if (accept) begin
        r15.pc_word <= r15.pc_word + NEXT_WORD;
        if (alu_go && ai.set_flags_bit) begin
          r15.neg_flag   <= res[31];
          r15.zero_flag  <= res == 32'h0;
          r15.carry_flag <= res_c;
          r15.ovf_flag   <= res_v;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // link_register banks
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 4; i++) begin
        link_bank[i] <= 32'h0;
      end
    end else if (ce) begin
      if (link_go) begin
        link_bank[r15.mode] <= link_value;
      end else if (alu_go && writes_result && ai.dest_reg == IDX_LINK) begin
        link_bank[r15.mode] <= res;
      end else if (reg_wr && reg_sel == IDX_LINK) begin
        link_bank[r15.mode] <= pwdata;
      end
    end
  end

  // general registers
  genvar g;
  generate
    for (g = 0; g < 14; g++) begin : g_gpr
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          gpr[g] <= 32'h0;
        end else if (ce) begin
          if (alu_go && writes_result && ai.dest_reg == 4'(g)) begin
            gpr[g] <= res;
          end else if (reg_wr && reg_sel == 4'(g)) begin
            gpr[g] <= pwdata;
          end
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // fetch redirect
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fetch_redirect <= 1'b0;
      fetch_target   <= 26'h0;
    end else if (ce) begin
      fetch_redirect <= br_go || alu_to_pc || stack_pc_valid;
      if (stack_pc_valid) begin
        fetch_target <= {stack_pc_word[25:2], 2'h0};
      end else if (br_go) begin
        fetch_target <= branch_target;
      end else if (alu_to_pc) begin
        fetch_target <= {res[25:2], 2'h0};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB registers
  logic mapped;

  assign mapped  = paddr == OFS_CTRL || paddr == OFS_STATUS || paddr == OFS_REG_SEL || paddr == OFS_REG_DATA;
  assign pready  = ce;
  assign pslverr = psel && penable && !mapped;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      run     <= 1'b0;
      reg_sel <= 4'h0;
    end else if (apb_wr) begin
      if (paddr == OFS_CTRL) begin
        run <= pwdata[CTRL_RUN_BIT];
      end
      if (paddr == OFS_REG_SEL) begin
        reg_sel <= pwdata[3:0];
      end
    end
  end

  // read data is captured in the setup cycle, so the access phase needs no wait
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h0;
    end else if (ce && psel && !penable) begin
      case (paddr)
        OFS_CTRL:     prdata <= {31'h0, run};
        OFS_STATUS:   prdata <= r15;
        OFS_REG_SEL:  prdata <= {28'h0, reg_sel};
        OFS_REG_DATA: prdata <= (reg_sel == IDX_PC) ? 32'(r15) : reg_read(reg_sel);
        default:      prdata <= 32'h0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  logic [23:0] pc_word_now;
  logic [31:0] link_now;
  logic [3:0]  flags_now;
  logic [23:0] res_word;

  assign pc_word_now = r15.pc_word;
  assign link_now    = link_bank[r15.mode];
  assign flags_now   = {r15.neg_flag, r15.zero_flag, r15.carry_flag, r15.ovf_flag};
  assign res_word    = res[25:2];

  AST_SKIP_ADVANCES: assert property (accept && !cond_ok |=>
    pc_word_now == $past(pc_word_now) + NEXT_WORD && !fetch_redirect)
    else $error("failed condition still changed flow");
  AST_BRANCH_TARGET: assert property (br_go |=> pc_word_now == $past(branch_word) && fetch_redirect)
    else $error("branch target wrong");
  AST_TARGET_AHEAD: assert property (br_go && bi.offset == 24'hFFFFFE |-> branch_word == r15.pc_word)
    else $error("prefetch offset not two words");
  AST_LINK_SAVED: assert property (link_go |=> link_now == {$past(flags_now), $past(r15.irq_off),
    $past(r15.firq_off), $past(pc_word_now) + NEXT_WORD, $past(r15.mode)}) else $error("link value wrong");
  AST_PLAIN_KEEPS_LINK: assert property (br_go && !bi.link |=> $stable(link_now))
    else $error("plain branch touched link");
  AST_NEVER_NOOP: assert property (accept && ai.cond == COND_NEVER |=>
    $stable(link_now) && $stable(flags_now) && !fetch_redirect) else $error("never condition had effect");
  AST_EQUAL_ZERO: assert property (accept && ai.cond == COND_EQUAL |-> exec == r15.zero_flag)
    else $error("equal condition ignores zero flag");
  AST_NO_S_KEEP: assert property (alu_go && !ai.set_flags_bit |=> $stable(flags_now))
    else $error("flags changed without set bit");
  AST_TEST_NO_LINK: assert property (alu_go && !writes_result && ai.dest_reg == IDX_LINK
    |=> $stable(link_now)) else $error("test operation wrote result");
  AST_PC_RELOAD: assert property (alu_to_pc && !ai.set_flags_bit |=>
    pc_word_now == $past(res_word) && $stable(flags_now)) else $error("pc reload changed status");

  COV_LINK_TAKEN: cover property (link_go);
  COV_BRANCH_SKIPPED: cover property (accept && is_branch && !cond_ok);
  COV_TEST_OP: cover property (alu_go && !writes_result && ai.set_flags_bit);
  COV_RESTORE: cover property (alu_to_pc && ai.set_flags_bit);

endmodule

// [tb/bad_fetch_model.sv]
// Purpose: fetch path model feeding the decode block from a sparse word memory
// Assumes: memory is filled by the bench while the core is stopped
// Notes:   unwritten words read as never-condition no-ops
module bad_fetch_model
  import bad_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // bench control
  input  wire logic        load,
  input  wire logic [23:0] load_word,
  input  wire logic        slow,
  // instruction stream
  output logic             instr_valid,
  output logic [31:0]      instr_data,
  input  wire logic        instr_ready,
  input  wire logic        fetch_redirect,
  input  wire logic [25:0] fetch_target
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] mem [logic [23:0]];
  logic [23:0] pc;
  logic [31:0] data_q;
  logic        phase;
  function automatic logic [31:0] word_at(input logic [23:0] a);
    return mem.exists(a) ? mem[a] : 32'hF0000000;
  endfunction
  ////////////////////////////////////////////////////////////////////////////
  // redirect wins over the step: the word offered after it comes from the target
  always_ff @(posedge clk or negedge rst_n) begin
    logic [23:0] npc;
    if (!rst_n) begin
      pc     <= 24'h000000;
      phase  <= 1'b0;
      data_q <= 32'hF0000000;
    end else begin
      npc = pc;
      if (load)
        npc = load_word;
      else if (fetch_redirect)
        npc = fetch_target[25:2];
      else if (instr_valid && instr_ready)
        npc = pc + 24'h000001;
      pc     <= npc;
      phase  <= ~phase;
      data_q <= word_at(npc);
    end
  end
  // slow mode offers every other cycle; idle data is scrambled, not held
  assign instr_valid = !slow || phase;
  assign instr_data  = instr_valid ? data_q : ~data_q;
endmodule

// [tb/bad_tb.sv]
// Purpose: directed bench for branch and ALU decode
// Assumes: registers reached over APB; core stopped while state is loaded
// Notes:   each program ends in a branch to itself so the final pc is fixed
module testbench
  import bad_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rst_n, ce, instr_valid, instr_ready, stack_pc_valid, stack_restore;
  logic        fetch_redirect, psel, penable, pwrite, pready, pslverr, load, slow;
  logic [31:0] instr_data, stack_pc_word, pwdata, prdata, v, exp_r [16];
  logic [25:0] fetch_target;
  logic [7:0]  paddr;
  logic [23:0] load_word;
  logic        e;
  int          n_errors, n_tests;
  localparam logic [31:0] RUN   = 32'h00000001 << CTRL_RUN_BIT;
  localparam logic [31:0] LINK0 = 32'hFC0000C3;
  localparam logic [31:0] LOOP  = 32'hEAFFFFFE;
  localparam logic [3:0]  C_FLG [7] = '{4'h0, 4'h0, 4'h0, 4'h4, 4'h0, 4'h0, 4'h0};
  localparam logic [31:0] C_INS [7] = '{32'hEB000004, 32'hEAFFFFE0, 32'h0A000004, 32'h0A000004,
                                        32'hFB000004, 32'hE1A0F00E, 32'hE1B0F00E};
  localparam logic [31:0] C_STA [7] = '{32'h0C00005B, 32'h0FFFFFCB, 32'h0C000047, 32'h4C00005B,
                                        32'h0C000047, 32'h0C0000C3, 32'hFC0000C3};
  localparam logic [31:0] C_LNK [7] = '{32'h0C000047, LINK0, LINK0, LINK0, LINK0, LINK0, LINK0};
  localparam logic [31:0] ALU_P [10] = '{32'hE3A014FF, 32'hE1513002, 32'h00814002, 32'hE1715002,
                                         32'h00816002, 32'hE3117000, 32'h00818002, 32'hE131E001,
                                         32'h0081A002, LOOP};
  bad_core uut (.clk(clk), .rst_n(rst_n), .ce(ce), .instr_valid(instr_valid), .instr_data(instr_data),
    .instr_ready(instr_ready), .stack_pc_valid(stack_pc_valid), .stack_pc_word(stack_pc_word),
    .stack_restore(stack_restore), .fetch_redirect(fetch_redirect), .fetch_target(fetch_target),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));
  bad_fetch_model fetch (.clk(clk), .rst_n(rst_n), .load(load), .load_word(load_word), .slow(slow),
    .instr_valid(instr_valid), .instr_data(instr_data), .instr_ready(instr_ready),
    .fetch_redirect(fetch_redirect), .fetch_target(fetch_target));
  ////////////////////////////////////////////////////////////////////////////
  always #4 clk = ~clk;
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] expv);
    n_tests++;
    if (seen !== expv) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", name, expv, seen);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // request held from setup until the edge that samples pready high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    v = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic reg_wr(input logic [3:0] i, input logic [31:0] d);
    apb(1'b1, OFS_REG_SEL, {28'h0000000, i});
    apb(1'b1, OFS_REG_DATA, d);
  endtask
  task automatic reg_rd(input logic [3:0] i);
    apb(1'b1, OFS_REG_SEL, {28'h0000000, i});
    apb(1'b0, OFS_REG_DATA, 32'h00000000);
  endtask
  task automatic run_case(input logic [23:0] start, input logic [31:0] stat, input logic slw);
    apb(1'b1, OFS_CTRL, 32'h00000000);
    reg_wr(4'hF, stat);
    @(posedge clk);
    load      <= 1'b1;
    load_word <= start;
    slow      <= slw;
    @(posedge clk);
    load <= 1'b0;
    apb(1'b1, OFS_CTRL, RUN);
    repeat (40) @(posedge clk);
    apb(1'b1, OFS_CTRL, 32'h00000000);
  endtask
  task automatic stack_pulse(input logic [31:0] w, input logic r);
    apb(1'b1, OFS_CTRL, RUN);
    @(posedge clk);
    stack_pc_valid <= 1'b1;
    stack_pc_word  <= w;
    stack_restore  <= r;
    @(posedge clk);
    stack_pc_valid <= 1'b0;
    stack_pc_word  <= ~w;
    stack_restore  <= ~r;
    repeat (10) @(posedge clk);
    apb(1'b1, OFS_CTRL, 32'h00000000);
    reg_rd(4'hF);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5000) @(posedge clk);
    n_errors++;
    end_sim();
  end
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    ce = 1'b1;
    {stack_pc_valid, stack_restore, psel, penable, pwrite, load, slow} = '0;
    {stack_pc_word, pwdata, paddr, load_word} = '0;
    n_errors = 0;
    n_tests = 0;
    fetch.mem[24'h000011] = LOOP;
    fetch.mem[24'h000016] = LOOP;
    fetch.mem[24'h000030] = LOOP;
    fetch.mem[24'hFFFFF2] = LOOP;
    for (int i = 0; i < 10; i++) fetch.mem[24'h000040 + 24'(i)] = ALU_P[i];
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    // reset state, read-only status, unmapped place
    apb(1'b0, OFS_STATUS, 32'h00000000);
    check("status_rst", v, R15_RST);
    apb(1'b1, OFS_STATUS, 32'h00000000);
    apb(1'b0, OFS_STATUS, 32'h00000000);
    check("status_ro", v, R15_RST);
    apb(1'b0, 8'h10, 32'h00000000);
    check("unmapped_err", {31'h00000000, e}, 32'h00000001);
    check("unmapped_data", v, 32'h00000000);
    $display("test reset done");
    // branch cases: link, wrap, equal condition, never condition, pc reload
    for (int c = 0; c < 7; c++) begin
      fetch.mem[24'h000010] = C_INS[c];
      apb(1'b1, OFS_CTRL, 32'h00000000);
      reg_wr(4'hE, LINK0);
      run_case(24'h000010, {C_FLG[c], 28'hC000043}, 1'b0);
      reg_rd(4'hF);
      check("branch_status", v, C_STA[c]);
      reg_rd(4'hE);
      check("branch_link", v, C_LNK[c]);
    end
    $display("test branch done");
    // ALU sequence with a stalling fetch path
    for (int i = 0; i < 16; i++) exp_r[i] = 32'h000000A0 + 32'(i);
    exp_r[2] = 32'hFF000000;
    apb(1'b1, OFS_CTRL, 32'h00000000);
    for (int i = 1; i < 14; i++) reg_wr(4'(i), exp_r[i]);
    exp_r[1] = 32'hFF000000;
    exp_r[4] = 32'hFE000000;
    exp_r[8] = 32'hFE000000;
    exp_r[10] = 32'hFE000000;
    run_case(24'h000040, 32'h0C000103, 1'b1);
    slow <= 1'b0;
    for (int i = 1; i < 14; i++) begin
      reg_rd(4'(i));
      check("alu_reg", v, exp_r[i]);
    end
    reg_rd(4'hF);
    check("alu_status", v, 32'h6C000127);
    reg_rd(4'hE);
    check("alu_link", v, LINK0);
    $display("test alu done");
    // load_multiple reload without and with status restore
    stack_pulse(32'h9C0000C3, 1'b0);
    check("stack_keep", v, 32'h6C0000C3);
    stack_pulse(32'h9C0000C3, 1'b1);
    check("stack_restore", v, 32'h9C0000C3);
    $display("test stack done");
    end_sim();
  end
endmodule
